// >>> hw/uhcc_defs.svh
`ifndef UHCC_DEFS_SVH
`define UHCC_DEFS_SVH
// Summary of operation
// - outside descriptor mode software sets enable; controller clears it when channel stops
// - in descriptor mode enable set means descriptors and buffers are ready to fetch
// - odd-frame bit picks even or odd frame for periodic; ignored in descriptor mode
// - seven-bit target device address selects the source or sink device
// - periodic without split, multi-count gives transactions per microframe; code zero undefined
// - non-periodic in DMA mode, multi-count sets packets fetched before arbitration moves
// - with split, multi-count gives immediate retries; software programs at least one
// - two-bit transfer type: control, isochronous, bulk, interrupt
// - direction bit, four-bit endpoint number and eleven-bit max packet size
// - split enable allows split transactions; complete-split bit requests complete phase
// - payload position for split OUT: all, first, middle, last
// - split register holds translator hub address and translator port number
// - descriptor mode only: wrap flag set when descriptor list rolls over
// - descriptor mode only: excess error flag after three consecutive errors, never isochronous
// - descriptor mode only: buffer unavailable flag on unready descriptor, never isochronous
// - descriptor mode masks toggle, overrun, babble, transaction error and response flags
// - transaction error flag set on CRC, timeout, bit stuffing or false end-of-packet
// - in DMA modes, system bus error flag set on failed read or write
// - stopped flag set whenever channel halts, causes depending on mode
// - done flag set on INTERRUPT_ON_COMPLETION descriptor completion or normal transfer end
// - mask bits for wrap and buffer unavailable, reserved outside descriptor mode
`define UHCC_OFS_CHAR      12'h0500
`define UHCC_OFS_SPLIT     12'h0504
`define UHCC_OFS_INT       12'h0508
`define UHCC_OFS_MASK      12'h050C
`define UHCC_CHAR_WMASK    32'hFFFE_FFFF
`define UHCC_SPLIT_WMASK   32'h8001_FF81
`define UHCC_MASK_WMASK    32'h0000_2FFF
`define UHCC_MASK_DESC     32'h0000_2804
`define UHCC_DESC_HIDDEN   14'h07F8
`define UHCC_ERR_LIMIT     2'h3
`define UHCC_POS_EN        31
`define UHCC_POS_DIS       30
`define UHCC_POS_WRAP      13
`define UHCC_POS_EXCESS    12
`define UHCC_POS_BNA       11
`define UHCC_POS_TOGGLE    10
`define UHCC_POS_OVERRUN   9
`define UHCC_POS_BABBLE    8
`define UHCC_POS_XACT      7
`define UHCC_POS_NYET      6
`define UHCC_POS_ACK       5
`define UHCC_POS_NAK       4
`define UHCC_POS_STALL     3
`define UHCC_POS_SYSBUS    2
`define UHCC_POS_HALT      1
`define UHCC_POS_DONE      0
`define UHCC_EP_ISO        2'h1
`endif

// >>> hw/uhcc_pkg.sv
package uhcc_pkg;
  typedef enum logic [1:0] {
    UHCC_EP_CONTROL = 2'h0,
    UHCC_EP_ISOCH   = 2'h1,
    UHCC_EP_BULK    = 2'h2,
    UHCC_EP_INTR    = 2'h3
  } uhcc_ep_e;

  typedef enum logic [1:0] {
    UHCC_BUS_IDLE = 2'b01,
    UHCC_BUS_ACK  = 2'b10
  } uhcc_bus_e;

  typedef struct packed {
    logic        enable;
    logic        abort;
    logic        odd_frame;
    logic [6:0]  dev_addr;
    logic [1:0]  multi_count;
    uhcc_ep_e    ep_type;
    logic        low_speed;
    logic        reserved;
    logic        dir_in;
    logic [3:0]  ep_num;
    logic [10:0] max_packet;
  } uhcc_char_s;

  typedef struct packed {
    logic        split_en;
    logic        complete_split;
    logic [1:0]  position;
    logic [6:0]  hub_addr;
    logic        port_num;
  } uhcc_split_s;
endpackage

// >>> hw/uhcc_wb_slave.sv
`include "uhcc_defs.svh"
module uhcc_wb_slave (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  output      logic        wb_ack_o,
  output      logic        wr_fire,
  output      logic        rd_fire,
  output      logic        we_fire
);
  typedef struct packed {
    uhcc_pkg::uhcc_bus_e st;
  } uhcc_wb_s;

  uhcc_wb_s state_reg;
  uhcc_wb_s state_next;

  // one access per request; ack one cycle after stb, then one idle cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.st)
      uhcc_pkg::UHCC_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_next.st = uhcc_pkg::UHCC_BUS_ACK;
        end
      end
      uhcc_pkg::UHCC_BUS_ACK: begin
        state_next.st = uhcc_pkg::UHCC_BUS_IDLE;
      end
      default: begin
        state_next.st = uhcc_pkg::UHCC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '{st: uhcc_pkg::UHCC_BUS_IDLE};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = (state_reg.st == uhcc_pkg::UHCC_BUS_ACK);
  assign wr_fire  = wb_ack_o && wb_we_i && clk_en;
  assign rd_fire  = wb_ack_o && !wb_we_i;
  assign we_fire  = wb_cyc_i && wb_stb_i && (state_reg.st == uhcc_pkg::UHCC_BUS_IDLE);
endmodule

// >>> hw/uhcc_status_bit.sv
module uhcc_status_bit (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic set,
  input  wire logic clear,
  output      logic flag
);
  typedef struct packed {
    logic flag;
  } uhcc_flag_s;

  uhcc_flag_s state_reg;
  uhcc_flag_s state_next;

  // set wins over a simultaneous write-one clear
  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.flag = 1'b0;
    end
    if (set) begin
      state_next.flag = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '{flag: 1'b0};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign flag = state_reg.flag;
endmodule

// >>> hw/uhcc_regs.sv
// The implementer's own choice: the Wishbone slave port.
`include "uhcc_defs.svh"
module uhcc_regs (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  input  wire logic        desc_mode,
  input  wire logic        dma_mode,
  input  wire logic        channel_stopped,
  input  wire logic        stop_transfer_done,
  input  wire logic        stop_xact_error,
  input  wire logic        stop_abort,
  input  wire logic        stop_end_of_list,
  input  wire logic        ev_xact_ok,
  input  wire logic        ev_crc_fail,
  input  wire logic        ev_timeout,
  input  wire logic        ev_bit_stuff,
  input  wire logic        ev_false_eop,
  input  wire logic        ev_toggle_mismatch,
  input  wire logic        ev_frame_overrun,
  input  wire logic        ev_babble,
  input  wire logic        ev_nyet,
  input  wire logic        ev_ack,
  input  wire logic        ev_nak,
  input  wire logic        ev_stall,
  input  wire logic        ev_sysbus_error,
  input  wire logic        ev_desc_wrap,
  input  wire logic        ev_desc_not_ready,
  input  wire logic        ev_desc_ioc_done,
  output      logic        channel_enable_bit,
  output      logic        channel_abort_request,
  output      logic        odd_frame_select,
  output      logic        periodic_channel,
  output      logic [6:0]  target_device_address,
  output      logic [1:0]  multi_count_retry_field,
  output      logic [1:0]  transactions_per_uframe,
  output      logic [1:0]  dma_fetch_packets,
  output      logic [1:0]  split_retry_count,
  output      logic        multi_count_invalid,
  output      logic [1:0]  transfer_type_field,
  output      logic        low_speed_target,
  output      logic        transfer_direction,
  output      logic [3:0]  target_endpoint_number,
  output      logic [10:0] max_packet_size,
  output      logic        split_transaction_enable,
  output      logic        complete_split_request,
  output      logic [1:0]  payload_position,
  output      logic        split_whole_payload,
  output      logic [6:0]  translator_hub_address,
  output      logic        translator_port_number,
  output      logic        channel_irq
);
  typedef struct packed {
    uhcc_pkg::uhcc_char_s  chr;
    uhcc_pkg::uhcc_split_s spl;
    logic [13:0]           mask;
    logic [1:0]            err_run;
    logic [31:0]           rdata;
  } uhcc_regs_s;

  uhcc_regs_s  state_reg;
  uhcc_regs_s  state_next;
  logic        wr_fire;
  logic        rd_fire;
  logic        req_take;
  logic [31:0] wmask_bytes;
  logic [13:0] set_vec;
  logic [13:0] clr_vec;
  logic [13:0] status;
  logic [13:0] irq_gate;
  logic        xact_err;
  logic        iso;
  logic        excess;
  logic [31:0] char_word;
  logic [31:0] split_word;
  logic [31:0] char_w;
  logic [31:0] split_w;

  uhcc_wb_slave u_bus (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_ack_o (wb_ack_o),
    .wr_fire  (wr_fire),
    .rd_fire  (rd_fire),
    .we_fire  (req_take)
  );

  assign wmask_bytes = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign iso = (state_reg.chr.ep_type == uhcc_pkg::UHCC_EP_ISOCH);
  assign xact_err = ev_crc_fail || ev_timeout || ev_bit_stuff || ev_false_eop;
  assign excess = desc_mode && !iso && xact_err
                  && (state_reg.err_run == (`UHCC_ERR_LIMIT - 2'h1));

  // event sources per status bit
  always_comb begin
    set_vec                   = '0;
    set_vec[`UHCC_POS_WRAP]    = desc_mode && ev_desc_wrap;
    set_vec[`UHCC_POS_EXCESS]  = excess;
    set_vec[`UHCC_POS_BNA]     = desc_mode && !iso && ev_desc_not_ready;
    set_vec[`UHCC_POS_TOGGLE]  = ev_toggle_mismatch;
    set_vec[`UHCC_POS_OVERRUN] = ev_frame_overrun;
    set_vec[`UHCC_POS_BABBLE]  = ev_babble;
    set_vec[`UHCC_POS_XACT]    = xact_err;
    set_vec[`UHCC_POS_NYET]    = ev_nyet;
    set_vec[`UHCC_POS_ACK]     = ev_ack;
    set_vec[`UHCC_POS_NAK]     = ev_nak;
    set_vec[`UHCC_POS_STALL]   = ev_stall;
    set_vec[`UHCC_POS_SYSBUS]  = dma_mode && ev_sysbus_error;
    set_vec[`UHCC_POS_HALT]    = channel_stopped;
    set_vec[`UHCC_POS_DONE]    = desc_mode ? ev_desc_ioc_done : stop_transfer_done;
  end

  assign clr_vec = (wr_fire && wb_adr_i == `UHCC_OFS_INT)
                   ? (wb_dat_i[13:0] & wmask_bytes[13:0]) : 14'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_stat
      uhcc_status_bit u_bit (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .set    (set_vec[gi]),
        .clear  (clr_vec[gi]),
        .flag   (status[gi])
      );
    end
  endgenerate

  assign char_word  = state_reg.chr;
  assign split_word = {state_reg.spl.split_en, 14'h0000, state_reg.spl.complete_split,
                       state_reg.spl.position, state_reg.spl.hub_addr, 6'h00,
                       state_reg.spl.port_num};
  assign char_w  = (char_word & ~(wmask_bytes & `UHCC_CHAR_WMASK))
                   | (wb_dat_i & wmask_bytes & `UHCC_CHAR_WMASK);
  assign split_w = (split_word & ~(wmask_bytes & `UHCC_SPLIT_WMASK))
                   | (wb_dat_i & wmask_bytes & `UHCC_SPLIT_WMASK);

  always_comb begin
    state_next = state_reg;
    if (xact_err) begin
      state_next.err_run = excess ? 2'h0 : state_reg.err_run + 2'h1;
    end else if (ev_xact_ok) begin
      state_next.err_run = 2'h0;
    end
    if (wr_fire) begin
      unique case (wb_adr_i)
        `UHCC_OFS_CHAR: begin
          state_next.chr = char_w;
        end
        `UHCC_OFS_SPLIT: begin
          state_next.spl = {split_w[31], split_w[16], split_w[15:14],
                            split_w[13:7], split_w[0]};
        end
        `UHCC_OFS_MASK: begin
          state_next.mask = (wb_dat_i[13:0] & wmask_bytes[13:0] & 14'(`UHCC_MASK_WMASK))
                            | (state_reg.mask & ~(wmask_bytes[13:0] & 14'(`UHCC_MASK_WMASK)));
        end
        default: begin
        end
      endcase
    end
    // hardware clears enable and abort when channel stops; this beats software
    if (channel_stopped) begin
      state_next.chr.enable = 1'b0;
      state_next.chr.abort  = 1'b0;
    end
    if (req_take && !wb_we_i) begin
      unique case (wb_adr_i)
        `UHCC_OFS_CHAR:  state_next.rdata = char_word;
        `UHCC_OFS_SPLIT: state_next.rdata = split_word;
        `UHCC_OFS_INT:   state_next.rdata = {18'h0_0000, status};
        `UHCC_OFS_MASK:  state_next.rdata = {18'h0_0000, state_reg.mask}
                                            & (desc_mode ? 32'hFFFF_FFFF : ~`UHCC_MASK_DESC);
        default:         state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o = state_reg.rdata;

  // descriptor mode hides response/error bits; outside it the wrap, buffer unavailable and system bus error bits are gated
  assign irq_gate = desc_mode ? (~`UHCC_DESC_HIDDEN) : (~14'(`UHCC_MASK_DESC));
  assign channel_irq = |(status & state_reg.mask & irq_gate);

  assign channel_enable_bit       = state_reg.chr.enable;
  assign channel_abort_request    = state_reg.chr.abort;
  assign odd_frame_select         = state_reg.chr.odd_frame && !desc_mode;
  assign periodic_channel         = state_reg.chr.ep_type[0];
  assign target_device_address    = state_reg.chr.dev_addr;
  assign multi_count_retry_field  = state_reg.chr.multi_count;
  assign transactions_per_uframe  = (!state_reg.spl.split_en && periodic_channel)
                                    ? state_reg.chr.multi_count : 2'h0;
  assign dma_fetch_packets        = (dma_mode && !periodic_channel)
                                    ? state_reg.chr.multi_count : 2'h0;
  assign split_retry_count        = state_reg.spl.split_en
                                    ? state_reg.chr.multi_count : 2'h0;
  assign multi_count_invalid      = (state_reg.chr.multi_count == 2'h0)
                                    && (periodic_channel || state_reg.spl.split_en);
  assign transfer_type_field      = state_reg.chr.ep_type;
  assign low_speed_target         = state_reg.chr.low_speed;
  assign transfer_direction       = state_reg.chr.dir_in;
  assign target_endpoint_number   = state_reg.chr.ep_num;
  assign max_packet_size          = state_reg.chr.max_packet;
  assign split_transaction_enable = state_reg.spl.split_en;
  assign complete_split_request   = state_reg.spl.complete_split;
  assign payload_position         = state_reg.spl.position;
  assign split_whole_payload      = (state_reg.spl.position == 2'h3);
  assign translator_hub_address   = state_reg.spl.hub_addr;
  assign translator_port_number   = state_reg.spl.port_num;
endmodule

// >>> dv/uhcc_regs_assertions.sv
module uhcc_regs_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        desc_mode,
  input wire logic        channel_stopped,
  input wire logic        channel_enable_bit,
  input wire logic        channel_abort_request,
  input wire logic        odd_frame_select,
  input wire logic        periodic_channel,
  input wire logic [1:0]  transfer_type_field,
  input wire logic        split_transaction_enable,
  input wire logic [1:0]  split_retry_count,
  input wire logic [1:0]  multi_count_retry_field,
  input wire logic [1:0]  payload_position,
  input wire logic        split_whole_payload,
  input wire logic [10:0] max_packet_size
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  sequence s_char_wr;
    wb_ack_o && wb_we_i && wb_adr_i == 12'h0500 && wb_sel_i == 4'hf && clk_en;
  endsequence
  chk_ack_one_cycle: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_single_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_stop_clears_enable: assert property (
    channel_stopped && clk_en |=> !channel_enable_bit && !channel_abort_request)
    else $error("enable or abort kept after channel stop");
  chk_odd_desc_ignored: assert property ((desc_mode ##1 desc_mode) |-> !odd_frame_select)
    else $error("odd frame select active in descriptor mode");
  chk_periodic_type: assert property (
    periodic_channel == (transfer_type_field == 2'h1 || transfer_type_field == 2'h3))
    else $error("periodic flag disagrees with transfer type");
  chk_whole_payload: assert property (split_whole_payload == (payload_position == 2'h3))
    else $error("whole payload flag disagrees with position");
  chk_split_retry: assert property (
    split_transaction_enable |-> split_retry_count == multi_count_retry_field)
    else $error("split retry count differs from multi count");
  chk_char_write: assert property (
    s_char_wr and !channel_stopped |=> max_packet_size == $past(wb_dat_i[10:0]))
    else $error("max packet size not taken from write");
endmodule

bind uhcc_regs uhcc_regs_assertions i_chk (
  .clock(clock), .rst(rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .desc_mode(desc_mode), .channel_stopped(channel_stopped),
  .channel_enable_bit(channel_enable_bit), .channel_abort_request(channel_abort_request),
  .odd_frame_select(odd_frame_select), .periodic_channel(periodic_channel),
  .transfer_type_field(transfer_type_field), .split_retry_count(split_retry_count),
  .split_transaction_enable(split_transaction_enable), .payload_position(payload_position),
  .multi_count_retry_field(multi_count_retry_field), .max_packet_size(max_packet_size),
  .split_whole_payload(split_whole_payload)
);

// >>> dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 0;
  logic        rst = 1;
  logic        wb_cyc_i = 0;
  logic        wb_stb_i = 0;
  logic        wb_we_i = 0;
  logic [11:0] wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic        desc_mode = 0;
  logic        dma_mode = 0;
  logic        clk_en = 1;
  logic [20:0] ev = '0;
  logic [31:0] wb_dat_o, rdat;
  logic        wb_ack_o, channel_enable_bit, channel_abort_request, odd_frame_select;
  logic        periodic_channel, multi_count_invalid, split_transaction_enable;
  logic        split_whole_payload, channel_irq;
  logic [6:0]  target_device_address, translator_hub_address;
  logic [3:0]  target_endpoint_number;
  logic        transfer_direction, complete_split_request, translator_port_number;
  logic [1:0]  multi_count_retry_field, transactions_per_uframe, dma_fetch_packets;
  logic [1:0]  split_retry_count, transfer_type_field, payload_position;
  logic [10:0] max_packet_size;
  int          mismatches = 0;
  int          comparisons = 0;

  uhcc_regs i_dut (
    .clock, .rst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .desc_mode, .dma_mode, .channel_stopped(ev[16]),
    .stop_transfer_done(ev[17]), .stop_xact_error(ev[18]), .stop_abort(ev[19]),
    .stop_end_of_list(ev[20]), .ev_xact_ok(ev[15]), .ev_crc_fail(ev[0]), .ev_timeout(ev[1]),
    .ev_bit_stuff(ev[2]), .ev_false_eop(ev[3]), .ev_toggle_mismatch(ev[4]),
    .ev_frame_overrun(ev[5]), .ev_babble(ev[6]), .ev_nyet(ev[7]), .ev_ack(ev[8]),
    .ev_nak(ev[9]), .ev_stall(ev[10]), .ev_sysbus_error(ev[11]), .ev_desc_wrap(ev[12]),
    .ev_desc_not_ready(ev[13]), .ev_desc_ioc_done(ev[14]), .channel_enable_bit,
    .channel_abort_request, .odd_frame_select, .periodic_channel, .target_device_address,
    .multi_count_retry_field, .transactions_per_uframe, .dma_fetch_packets,
    .split_retry_count, .multi_count_invalid, .transfer_type_field, .low_speed_target(),
    .transfer_direction, .target_endpoint_number, .max_packet_size,
    .split_transaction_enable, .complete_split_request, .payload_position,
    .split_whole_payload, .translator_hub_address, .translator_port_number, .channel_irq
  );

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic print_verdict;
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (n >= 50) mismatches++;
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] e, string n);
    bus(0, a, '0);
    cmp(n, e, rdat);
  endtask

  task automatic pulse(logic [20:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= '0;
  endtask

  task automatic settle;
    @(posedge clock);
  endtask

  task automatic t_reset;
    bus(1, 12'h510, 32'hffff_ffff);
    for (int i = 0; i < 5; i++) rd(12'h500 + 12'(4 * i), '0, "reset");
  endtask

  task automatic t_char;
    bus(1, 12'h500, 32'hffff_ffff);
    rd(12'h500, 32'hfffe_ffff, "char");
    cmp("dev", 32'h0000_007f, 32'(target_device_address));
    cmp("mps", 32'h0000_07ff, 32'(max_packet_size));
    cmp("ep", 32'h0000_000f, 32'(target_endpoint_number));
    cmp("dir", 32'h0000_0001, 32'(transfer_direction));
    cmp("en", 32'h0000_0001, 32'(channel_enable_bit));
    cmp("odd", 32'h0000_0001, 32'(odd_frame_select));
    desc_mode <= 1;
    settle;
    settle;
    cmp("odd", '0, 32'(odd_frame_select));
    desc_mode <= 0;
    pulse(21'h09_0000);
    settle;
    cmp("en", '0, 32'(channel_enable_bit));
    cmp("abort", '0, 32'(channel_abort_request));
    rd(12'h508, 32'h0000_0002, "halt");
    pulse(21'h02_0000);
    rd(12'h508, 32'h0000_0003, "done");
    bus(1, 12'h508, 32'h0000_0001);
    rd(12'h508, 32'h0000_0002, "w1c");
    bus(1, 12'h508, 32'hffff_ffff);
  endtask

  task automatic t_types;
    for (int t = 0; t < 4; t++) begin
      bus(1, 12'h500, 32'(t) << 18);
      settle;
      cmp("type", 32'(t), 32'(transfer_type_field));
      cmp("per", 32'(t % 2), 32'(periodic_channel));
    end
    bus(1, 12'h500, 32'h002c_0000);
    settle;
    cmp("tpu", 32'h0000_0002, 32'(transactions_per_uframe));
    cmp("mcinv", '0, 32'(multi_count_invalid));
    bus(1, 12'h500, 32'h000c_0000);
    settle;
    cmp("mcinv", 32'h0000_0001, 32'(multi_count_invalid));
    dma_mode <= 1;
    bus(1, 12'h500, 32'h0038_0000);
    settle;
    cmp("fetch", 32'h0000_0003, 32'(dma_fetch_packets));
    bus(1, 12'h504, 32'h8000_0000);
    bus(1, 12'h500, 32'h0014_0000);
    settle;
    cmp("retry", 32'h0000_0001, 32'(split_retry_count));
    cmp("tpu", '0, 32'(transactions_per_uframe));
    dma_mode <= 0;
  endtask

  task automatic t_split;
    bus(1, 12'h504, 32'hffff_ffff);
    rd(12'h504, 32'h8001_ff81, "split");
    cmp("csplit", 32'h0000_0001, 32'(complete_split_request));
    cmp("hub", 32'h0000_007f, 32'(translator_hub_address));
    cmp("port", 32'h0000_0001, 32'(translator_port_number));
    cmp("pos", 32'h0000_0003, 32'(payload_position));
    for (int p = 0; p < 4; p++) begin
      bus(1, 12'h504, 32'(p) << 14);
      settle;
      cmp("whole", 32'(p == 3), 32'(split_whole_payload));
    end
  endtask

  task automatic t_status;
    int b[11] = '{7, 7, 7, 7, 10, 9, 8, 6, 5, 4, 3};
    for (int i = 0; i < 11; i++) begin
      pulse(21'(1) << i);
      rd(12'h508, 32'(1) << b[i], "stat");
      bus(1, 12'h508, 32'hffff_ffff);
    end
    rd(12'h508, '0, "clr");
    pulse(21'h00_0800);
    rd(12'h508, '0, "sysbus");
    dma_mode <= 1;
    pulse(21'h00_0800);
    rd(12'h508, 32'h0000_0004, "sysbus");
    bus(1, 12'h508, 32'hffff_ffff);
    bus(1, 12'h50c, 32'h0000_0080);
    pulse(21'h00_0001);
    settle;
    cmp("irq", 32'h0000_0001, 32'(channel_irq));
    bus(1, 12'h508, 32'h0000_0080);
    settle;
    cmp("irq", '0, 32'(channel_irq));
    desc_mode <= 1;
    pulse(21'h00_0001);
    settle;
    cmp("irq", '0, 32'(channel_irq));
    bus(1, 12'h50c, 32'hffff_ffff);
    rd(12'h50c, 32'h0000_2fff, "mask");
    bus(1, 12'h500, 32'h0008_0000);
    pulse(21'h00_8000);
    for (int i = 0; i < 3; i++) pulse(21'h00_0001);
    rd(12'h508, 32'h0000_1080, "excess");
    bus(1, 12'h508, 32'hffff_ffff);
    pulse(21'h00_1000);
    settle;
    cmp("irq", 32'h0000_0001, 32'(channel_irq));
    rd(12'h508, 32'h0000_2000, "wrap");
    bus(1, 12'h508, 32'hffff_ffff);
    pulse(21'h00_6000);
    rd(12'h508, 32'h0000_0801, "bna");
    bus(1, 12'h508, 32'hffff_ffff);
    bus(1, 12'h500, 32'h0004_0000);
    pulse(21'h00_2000);
    rd(12'h508, '0, "iso");
    desc_mode <= 0;
    pulse(21'h00_1000);
    rd(12'h508, '0, "wrap");
    bus(0, 12'h50c, '0);
    cmp("mskres", '0, rdat & 32'h0000_2800);
    clk_en <= 0;
    pulse(21'h00_0001);
    clk_en <= 1;
    rd(12'h508, '0, "frozen");
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    t_reset;
    t_char;
    t_types;
    t_split;
    t_status;
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    print_verdict;
  end
endmodule
